// ===== rtl/mspt_pkg.sv
// Shared constants for the motion sensor serial port core
package mspt_pkg;

   // Clock period of the core clock
   localparam int unsigned CLK_PERIOD_PS = 5000;

   // Timing figures as specified
   localparam int unsigned MOT_RST_MAX_MS = 23;
   localparam int unsigned WAKEUP_MIN_MS = 23;
   localparam int unsigned SHUTDOWN_MAX_MS = 50;
   localparam int unsigned MISO_HIZ_MAX_NS = 500;

   // Longest times round down, least times round up
   localparam int unsigned MOT_RST_CYC = (MOT_RST_MAX_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned WAKEUP_CYC = (WAKEUP_MIN_MS * 1000000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned SHUTDOWN_CYC = (SHUTDOWN_MAX_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned MISO_HIZ_CYC = (MISO_HIZ_MAX_NS * 1000) / CLK_PERIOD_PS;

   // Synchroniser depths
   localparam int unsigned SEL_SYNC_DEPTH = 3;
   localparam int unsigned EVT_SYNC_DEPTH = 4;

   // Command byte and motion register bit layout
   localparam int unsigned CMD_DIR_BIT = 7;
   localparam int unsigned MOTION_FLAG_BIT = 7;

   // Register addresses
   localparam logic [6:0] ADDR_MOTION = 7'h02;
   localparam logic [6:0] ADDR_DELTA_X = 7'h03;
   localparam logic [6:0] ADDR_DELTA_Y = 7'h04;
   localparam logic [6:0] ADDR_QUALITY = 7'h05;
   localparam logic [6:0] ADDR_EXPO_HI = 7'h06;
   localparam logic [6:0] ADDR_EXPO_LO = 7'h07;
   localparam logic [6:0] ADDR_PEAK = 7'h08;
   localparam logic [6:0] ADDR_SHUTDOWN = 7'h39;
   localparam logic [6:0] ADDR_RESTART = 7'h3a;
   localparam logic [6:0] ADDR_BURST = 7'h42;

   // Key values that trigger restart and shutdown
   localparam logic [7:0] RESTART_KEY = 8'h5a;
   localparam logic [7:0] SHUTDOWN_KEY = 8'he7;

   // Burst sequence length
   localparam logic [2:0] BURST_LEN = 3'h7;

   // Power states
   typedef enum logic [1:0] {
      PWR_WARM,
      PWR_RUN,
      PWR_STOPPING,
      PWR_OFF
   } mspt_pwr_e;

endpackage

// ===== rtl/mspt_link.sv
// Serial clock domain shifter of the motion sensor port
`timescale 1ns/100ps
`default_nettype none
module mspt_link (
   input wire logic sclk_i,
   input wire logic port_select_n_i,
   input wire logic mosi_i,
   input wire logic [8*mspt_pkg::BURST_LEN-1:0] tx_word_i,
   output logic [7:0] rx_byte_o,
   output logic rx_toggle_o,
   output logic miso_o
);

   logic [2:0] bit_cnt;
   logic [6:0] in_sh;
   logic [7:0] out_sh;
   wire byte_end = (bit_cnt == 3'h7);
   wire [7:0] rx_full = {in_sh, mosi_i};
   logic [3:0] byte_no;
   wire [2:0] data_idx = 3'(byte_no - 4'h1);
   wire [8*mspt_pkg::BURST_LEN+7:0] tx_ext = {8'h00, tx_word_i};
   wire [7:0] tx_pick = (byte_no == 4'h0) ? 8'h00 : tx_ext[data_idx*8 +: 8];

   always_ff @(posedge sclk_i or posedge port_select_n_i) begin
      if (port_select_n_i) begin
         bit_cnt <= 3'h0;
         in_sh <= 7'h00;
         rx_byte_o <= 8'h00;
         rx_toggle_o <= 1'b0;
         byte_no <= 4'h0;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         in_sh <= rx_full[6:0];
         if (byte_end) begin
            rx_byte_o <= rx_full;
            rx_toggle_o <= ~rx_toggle_o;
            if (byte_no != 4'(mspt_pkg::BURST_LEN) + 4'h1) begin
               byte_no <= byte_no + 4'h1;
            end
         end
      end
   end

   always_ff @(negedge sclk_i or posedge port_select_n_i) begin
      if (port_select_n_i) begin
         out_sh <= 8'h00;
      end else if (bit_cnt == 3'h0) begin
         out_sh <= tx_pick;
      end else begin
         out_sh <= {out_sh[6:0], 1'b0};
      end
   end

   assign miso_o = out_sh[7];

endmodule // mspt_link
`default_nettype wire

// ===== rtl/mspt_core.sv
// Motion sensor serial port core with movement indicator and power control
`timescale 1ns/100ps
`default_nettype none
module mspt_core #(
   parameter int unsigned RESTART_CYC = mspt_pkg::MOT_RST_CYC,
   parameter int unsigned STOP_CYC = mspt_pkg::SHUTDOWN_CYC
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic sclk_i,
   input wire logic port_select_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic motion_n_o,
   output logic laser_emitter_o,
   output logic low_power_o,
   input wire logic capture_request_i,
   input wire logic frame_valid_i,
   input wire logic [7:0] frame_dx_i,
   input wire logic [7:0] frame_dy_i,
   input wire logic [7:0] frame_quality_i,
   input wire logic [15:0] frame_exposure_i,
   input wire logic [7:0] frame_peak_i
);

   // Elaboration checks
   if (RESTART_CYC < 1 || RESTART_CYC > mspt_pkg::MOT_RST_CYC || RESTART_CYC < mspt_pkg::WAKEUP_CYC / 2 ** 31)
      $error("restart count out of range");
   if (STOP_CYC < 1 || STOP_CYC > mspt_pkg::SHUTDOWN_CYC)
      $error("shutdown count out of range");
   if (mspt_pkg::SEL_SYNC_DEPTH + 1 > mspt_pkg::MISO_HIZ_CYC)
      $error("select synchroniser too slow for output release");

   localparam int unsigned TXW = 8 * int'(mspt_pkg::BURST_LEN);
   logic [7:0] rx_byte;
   logic rx_toggle;
   logic [TXW-1:0] tx_word;

   mspt_link u_link (
      .sclk_i(sclk_i),
      .port_select_n_i(port_select_n_i),
      .mosi_i(mosi_i),
      .tx_word_i(tx_word),
      .rx_byte_o(rx_byte),
      .rx_toggle_o(rx_toggle),
      .miso_o(miso_o)
   );

   // Pin and event synchronisers
   logic [mspt_pkg::SEL_SYNC_DEPTH-1:0] sel_sh;
   logic [mspt_pkg::EVT_SYNC_DEPTH-1:0] tog_sh;
   logic sel_idle;
   logic tog_stable;
   logic tog_seen;
   localparam int unsigned SL = mspt_pkg::SEL_SYNC_DEPTH - 1;
   localparam int unsigned TL = mspt_pkg::EVT_SYNC_DEPTH - 1;

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         sel_sh <= '1;
         tog_sh <= '0;
         sel_idle <= 1'b1;
         tog_stable <= 1'b0;
      end else begin
         sel_sh <= {sel_sh[SL-1:0], port_select_n_i};
         tog_sh <= {tog_sh[TL-1:0], rx_toggle};
         if (sel_sh[SL] == sel_sh[SL-1]) begin
            sel_idle <= sel_sh[SL];
         end
         if (tog_sh[TL] == tog_sh[TL-1]) begin
            tog_stable <= tog_sh[TL];
         end
      end
   end

   // Transaction tracking
   // late select rise after write
   wire byte_evt = !sel_idle && (tog_stable != tog_seen);
   logic [1:0] byte_cnt;
   logic is_write;
   logic in_burst;
   logic [2:0] burst_ptr;
   logic [6:0] cmd_addr;
   mspt_pkg::mspt_pwr_e pwr_state;
   logic [31:0] pwr_cnt;

   // Sensor data registers
   logic motion_flag;
   logic [7:0] acc_dx;
   logic [7:0] acc_dy;
   logic [7:0] quality;
   logic [15:0] exposure;
   logic [7:0] peak;
   logic seen_dx;
   logic seen_dy;

   function automatic logic [6:0] burst_addr(input logic [2:0] idx);
      case (idx)
         3'h0: burst_addr = mspt_pkg::ADDR_MOTION;
         3'h1: burst_addr = mspt_pkg::ADDR_DELTA_X;
         3'h2: burst_addr = mspt_pkg::ADDR_DELTA_Y;
         3'h3: burst_addr = mspt_pkg::ADDR_QUALITY;
         3'h4: burst_addr = mspt_pkg::ADDR_EXPO_HI;
         3'h5: burst_addr = mspt_pkg::ADDR_EXPO_LO;
         default: burst_addr = mspt_pkg::ADDR_PEAK;
      endcase
   endfunction

   function automatic logic [7:0] reg_value(input logic [6:0] addr, input logic mflag, input logic [7:0] dx,
                                            input logic [7:0] dy, input logic [7:0] q, input logic [15:0] ex,
                                            input logic [7:0] pk);
      case (addr)
         mspt_pkg::ADDR_MOTION: reg_value = 8'(mflag) << mspt_pkg::MOTION_FLAG_BIT;
         mspt_pkg::ADDR_DELTA_X: reg_value = dx;
         mspt_pkg::ADDR_DELTA_Y: reg_value = dy;
         mspt_pkg::ADDR_QUALITY: reg_value = q;
         mspt_pkg::ADDR_EXPO_HI: reg_value = ex[15:8];
         mspt_pkg::ADDR_EXPO_LO: reg_value = ex[7:0];
         mspt_pkg::ADDR_PEAK: reg_value = pk;
         default: reg_value = 8'h00;
      endcase
   endfunction

   function automatic logic [TXW-1:0] burst_word(input logic mflag, input logic [7:0] dx, input logic [7:0] dy,
                                                 input logic [7:0] q, input logic [15:0] ex, input logic [7:0] pk);
      burst_word = '0;
      for (int i = 0; i < int'(mspt_pkg::BURST_LEN); i++) begin
         burst_word[i*8 +: 8] = reg_value(burst_addr(3'(i)), mflag, dx, dy, q, ex, pk);
      end
   endfunction

   wire first_byte = byte_evt && (byte_cnt == 2'h0);
   wire first_is_read = first_byte && !rx_byte[mspt_pkg::CMD_DIR_BIT];
   wire burst_start = first_is_read && (rx_byte[6:0] == mspt_pkg::ADDR_BURST);
   wire burst_step = byte_evt && in_burst && (burst_ptr < mspt_pkg::BURST_LEN);
   wire [6:0] rd_addr = burst_start ? burst_addr(3'h0) : (burst_step ? burst_addr(burst_ptr) : rx_byte[6:0]);
   wire rd_take = burst_start || burst_step || first_is_read;
   wire [7:0] rd_data = reg_value(rd_addr, motion_flag, acc_dx, acc_dy, quality, exposure, peak);
   wire wr_take = byte_evt && is_write && (byte_cnt == 2'h1);
   wire running = (pwr_state == mspt_pkg::PWR_RUN);
   wire restart_wr = wr_take && (cmd_addr == mspt_pkg::ADDR_RESTART) && (rx_byte == mspt_pkg::RESTART_KEY);
   wire shutdown_wr = wr_take && running && (cmd_addr == mspt_pkg::ADDR_SHUTDOWN) &&
                      (rx_byte == mspt_pkg::SHUTDOWN_KEY);
   wire motion_wr = wr_take && running && (cmd_addr == mspt_pkg::ADDR_MOTION);
   wire read_dx = rd_take && (rd_addr == mspt_pkg::ADDR_DELTA_X);
   wire read_dy = rd_take && (rd_addr == mspt_pkg::ADDR_DELTA_Y);
   wire both_read = (seen_dx || read_dx) && (seen_dy || read_dy);
   wire motion_clr = motion_wr || both_read;
   wire new_move = running && frame_valid_i && ((frame_dx_i != 8'h00) || (frame_dy_i != 8'h00));

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         tog_seen <= 1'b0;
         byte_cnt <= 2'h0;
         is_write <= 1'b0;
         in_burst <= 1'b0;
         burst_ptr <= 3'h0;
         cmd_addr <= 7'h00;
         tx_word <= '0;
      end else if (sel_idle) begin
         tog_seen <= 1'b0;
         byte_cnt <= 2'h0;
         is_write <= 1'b0;
         in_burst <= 1'b0;
         burst_ptr <= 3'h0;
      end else if (byte_evt) begin
         tog_seen <= tog_stable;
         if (byte_cnt != 2'h3) begin
            byte_cnt <= byte_cnt + 2'h1;
         end
         if (first_byte) begin
            cmd_addr <= rx_byte[6:0];
            is_write <= rx_byte[mspt_pkg::CMD_DIR_BIT];
            in_burst <= burst_start;
            burst_ptr <= 3'h1;
            tx_word <= burst_start ? burst_word(motion_flag, acc_dx, acc_dy, quality, exposure, peak) : TXW'(rd_data);
         end else if (burst_step) begin
            burst_ptr <= burst_ptr + 3'h1;
         end
      end
   end

   // Movement accumulation, set wins over clear
   always_ff @(posedge clock_i) begin
      if (!resetn_i || restart_wr) begin
         motion_flag <= 1'b0;
         acc_dx <= 8'h00;
         acc_dy <= 8'h00;
         quality <= 8'h00;
         exposure <= 16'h0000;
         peak <= 8'h00;
         seen_dx <= 1'b0;
         seen_dy <= 1'b0;
      end else begin
         motion_flag <= new_move || (motion_flag && !motion_clr);
         acc_dx <= (motion_clr ? 8'h00 : acc_dx) + (new_move ? frame_dx_i : 8'h00);
         acc_dy <= (motion_clr ? 8'h00 : acc_dy) + (new_move ? frame_dy_i : 8'h00);
         seen_dx <= !motion_clr && (seen_dx || read_dx);
         seen_dy <= !motion_clr && (seen_dy || read_dy);
         if (running && frame_valid_i) begin
            quality <= frame_quality_i;
            exposure <= frame_exposure_i;
            peak <= frame_peak_i;
         end
      end
   end

   // Power state machine
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         pwr_state <= mspt_pkg::PWR_WARM;
         pwr_cnt <= 32'h0;
      end else if (restart_wr) begin
         pwr_state <= mspt_pkg::PWR_WARM;
         pwr_cnt <= 32'h0;
      end else begin
         case (pwr_state)
            mspt_pkg::PWR_WARM: begin
               if (pwr_cnt >= 32'(RESTART_CYC - 1)) begin
                  pwr_state <= mspt_pkg::PWR_RUN;
                  pwr_cnt <= 32'h0;
               end else begin
                  pwr_cnt <= pwr_cnt + 32'h1;
               end
            end
            mspt_pkg::PWR_RUN: begin
               if (shutdown_wr) begin
                  pwr_state <= mspt_pkg::PWR_STOPPING;
                  pwr_cnt <= 32'h0;
               end
            end
            mspt_pkg::PWR_STOPPING: begin
               if (pwr_cnt >= 32'(STOP_CYC - 1)) begin
                  pwr_state <= mspt_pkg::PWR_OFF;
               end else begin
                  pwr_cnt <= pwr_cnt + 32'h1;
               end
            end
            mspt_pkg::PWR_OFF: begin
               pwr_cnt <= 32'h0;
            end
            default: begin
               pwr_state <= mspt_pkg::PWR_WARM;
               pwr_cnt <= 32'h0;
            end
         endcase
      end
   end

   // Output registers
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         miso_oe_o <= 1'b0;
         motion_n_o <= 1'b1;
         laser_emitter_o <= 1'b0;
         low_power_o <= 1'b0;
      end else begin
         miso_oe_o <= !sel_idle;
         motion_n_o <= !motion_flag;
         laser_emitter_o <= capture_request_i && (pwr_state == mspt_pkg::PWR_WARM || running);
         low_power_o <= (pwr_state == mspt_pkg::PWR_OFF);
      end
   end

endmodule // mspt_core
`default_nettype wire

// ===== sim/mspt_core_chk.sv
// Port assertions for the motion sensor port core
`timescale 1ns/100ps
`default_nettype none
module mspt_core_chk #(
   parameter int unsigned RESTART_CYC = 20,
   parameter int unsigned STOP_CYC = 20
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic sclk_i,
   input wire logic port_select_n_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic motion_n_o,
   input wire logic laser_emitter_o,
   input wire logic low_power_o,
   input wire logic capture_request_i,
   input wire logic frame_valid_i
);
   logic [31:0] warm_cnt;
   logic [31:0] dark_cnt;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   always_ff @(posedge clock_i) begin
      if (!resetn_i || $fell(low_power_o)) begin
         warm_cnt <= 32'h0;
      end else if (warm_cnt < 32'hffff) begin
         warm_cnt <= warm_cnt + 32'h1;
      end
      if (!resetn_i || laser_emitter_o) begin
         dark_cnt <= 32'h0;
      end else if (dark_cnt < 32'hffff) begin
         dark_cnt <= dark_cnt + 32'h1;
      end
   end
   oe_release_a: assert property ($rose(port_select_n_i) |-> ##[1:100] !miso_oe_o)
      else $error("miso drive held after select rose");
   oe_idle_a: assert property (port_select_n_i [*8] |-> !miso_oe_o)
      else $error("miso driven while not selected");
   oe_enable_a: assert property ($fell(port_select_n_i) |-> ##[1:8] miso_oe_o)
      else $error("miso not driven after select fell");
   miso_hold_a: assert property (!port_select_n_i && $past(!port_select_n_i) && !$fell(sclk_i) |-> $stable(miso_o))
      else $error("miso changed between falling clocks");
   laser_copy_a: assert property (laser_emitter_o |-> $past(capture_request_i))
      else $error("laser lit without capture request");
   motion_cause_a: assert property ($fell(motion_n_o) |-> $past(frame_valid_i, 2) || $past(frame_valid_i, 3))
      else $error("motion indicator fell without frame");
   warm_gap_a: assert property (warm_cnt + 2 < RESTART_CYC |-> !$fell(motion_n_o))
      else $error("motion reported during warm up");
   stop_gap_a: assert property ($rose(low_power_o) |-> dark_cnt + 2 >= STOP_CYC)
      else $error("low power reached too early");
   lp_dark_a: assert property (low_power_o |-> !laser_emitter_o)
      else $error("laser lit in low power");
   cover property ($fell(motion_n_o));
   cover property ($rose(motion_n_o));
   cover property ($rose(low_power_o));
endmodule // mspt_core_chk
bind mspt_core mspt_core_chk #(.RESTART_CYC(RESTART_CYC), .STOP_CYC(STOP_CYC)) mspt_core_chk_inst (.*);
`default_nettype wire

// ===== sim/mspt_host.sv
// Host master model driving the serial port
`timescale 1ns/100ps
`default_nettype none
module mspt_host (
   input wire logic clock_i,
   input wire logic miso_i,
   output logic sclk_o,
   output logic port_select_n_o,
   output logic mosi_o
);
   logic [7:0] got [0:6];
   initial begin
      sclk_o = 1'b1;
      port_select_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic gap(input int unsigned ns);
      repeat ((ns + 4) / 5) @(posedge clock_i);
      #1.3;
   endtask
   task automatic shift(input logic [7:0] tx, input int unsigned nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - int'(nbits); i--) begin
         sclk_o = 1'b0;
         mosi_o = tx[i];
         #24;
         sclk_o = 1'b1;
         rx[i] = miso_i;
         #24;
      end
   endtask
   task automatic open_frame();
      port_select_n_o = 1'b0;
      gap(120);
   endtask
   task automatic close_frame(input int unsigned hold_ns, input int unsigned gap_ns);
      gap(hold_ns);
      port_select_n_o = 1'b1;
      mosi_o = ~mosi_o;
      gap(gap_ns);
   endtask
   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data, input int unsigned nbits);
      logic [7:0] rx;
      open_frame();
      shift({1'b1, addr}, 8, rx);
      shift(data, nbits, rx);
      close_frame(20000, 10000);
   endtask
   task automatic read_reg(input logic [6:0] addr, input int unsigned count);
      logic [7:0] rx;
      open_frame();
      shift({1'b0, addr}, 8, rx);
      gap(4000);
      for (int b = 0; b < int'(count); b++) begin
         shift(8'h00, 8, rx);
         got[b] = rx;
      end
      close_frame(120, 500);
   endtask
endmodule // mspt_host
`default_nettype wire

// ===== sim/test_motion_sensor_port_timing.sv
// Testbench of the motion sensor port core
`timescale 1ns/100ps
`default_nettype none
module test_motion_sensor_port_timing;
   logic clock_i, resetn_i, capture, fvalid;
   logic [7:0] dx, dy;
   wire logic sclk, sel_n, mosi, miso, miso_oe, motion_n, laser, low_power;
   wire logic miso_w;
   int bad_count = 0;
   int cmp_count = 0;
   assign miso_w = miso_oe ? miso : 1'bz;
   mspt_core #(.RESTART_CYC(20), .STOP_CYC(20)) mspt_core_inst (.clock_i(clock_i), .resetn_i(resetn_i),
      .sclk_i(sclk), .port_select_n_i(sel_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
      .motion_n_o(motion_n), .laser_emitter_o(laser), .low_power_o(low_power), .capture_request_i(capture),
      .frame_valid_i(fvalid), .frame_dx_i(dx), .frame_dy_i(dy), .frame_quality_i(dx ^ 8'h5a),
      .frame_exposure_i({dy, dx}), .frame_peak_i(~dx));
   mspt_host mspt_host_inst (.clock_i(clock_i), .miso_i(miso_w), .sclk_o(sclk), .port_select_n_o(sel_n),
      .mosi_o(mosi));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic frame(input logic [7:0] x, input logic [7:0] y);
      @(posedge clock_i) #1;
      fvalid = 1'b1;
      dx = x;
      dy = y;
      @(posedge clock_i) #1;
      fvalid = 1'b0;
      repeat (4) @(posedge clock_i);
      #1;
   endtask
   task automatic t_laser();
      capture = 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      check({7'h00, laser}, 8'h01);
      capture = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      check({7'h00, laser}, 8'h00);
   endtask
   task automatic t_read();
      frame(8'h05, 8'hfd);
      check({7'h00, motion_n}, 8'h00);
      mspt_host_inst.read_reg(mspt_pkg::ADDR_MOTION, 1);
      check({7'h00, mspt_host_inst.got[0][mspt_pkg::MOTION_FLAG_BIT]}, 8'h01);
      mspt_host_inst.read_reg(mspt_pkg::ADDR_DELTA_X, 1);
      check(mspt_host_inst.got[0], 8'h05);
      check({7'h00, motion_n}, 8'h00);
      mspt_host_inst.read_reg(mspt_pkg::ADDR_DELTA_Y, 1);
      check(mspt_host_inst.got[0], 8'hfd);
      check({7'h00, motion_n}, 8'h01);
   endtask
   task automatic t_abort();
      frame(8'h01, 8'h00);
      mspt_host_inst.write_reg(mspt_pkg::ADDR_MOTION, 8'h00, 4);
      check({7'h00, motion_n}, 8'h00);
      mspt_host_inst.write_reg(mspt_pkg::ADDR_MOTION, 8'h00, 8);
      check({7'h00, motion_n}, 8'h01);
   endtask
   task automatic t_burst();
      logic [7:0] exp [1:6];
      exp = '{8'h12, 8'h34, 8'h12 ^ 8'h5a, 8'h34, 8'h12, 8'hed};
      frame(8'h12, 8'h34);
      mspt_host_inst.read_reg(mspt_pkg::ADDR_BURST, 7);
      check({7'h00, mspt_host_inst.got[0][mspt_pkg::MOTION_FLAG_BIT]}, 8'h01);
      for (int i = 1; i < 7; i++) begin
         check(mspt_host_inst.got[i], exp[i]);
      end
      check({6'h00, motion_n, miso_oe}, 8'h02);
   endtask
   task automatic t_power();
      capture = 1'b1;
      mspt_host_inst.write_reg(mspt_pkg::ADDR_SHUTDOWN, mspt_pkg::SHUTDOWN_KEY, 8);
      check({6'h00, laser, low_power}, 8'h01);
      frame(8'h01, 8'h01);
      check({7'h00, motion_n}, 8'h01);
      mspt_host_inst.write_reg(mspt_pkg::ADDR_RESTART, mspt_pkg::RESTART_KEY, 8);
      check({6'h00, laser, low_power}, 8'h02);
      frame(8'h02, 8'h00);
      check({7'h00, motion_n}, 8'h00);
      capture = 1'b0;
   endtask
   initial begin
      resetn_i = 1'b0;
      capture = 1'b0;
      fvalid = 1'b0;
      dx = 8'h00;
      dy = 8'h00;
      repeat (3) @(posedge clock_i);
      #1;
      resetn_i = 1'b1;
      repeat (30) @(posedge clock_i);
      #1;
      t_laser();
      t_read();
      t_abort();
      t_burst();
      t_power();
      wrap_up();
   end
   initial begin
      repeat (60000) @(posedge clock_i);
      bad_count++;
      wrap_up();
   end
endmodule // test_motion_sensor_port_timing
`default_nettype wire
